// ---- core/touch_pkg.sv ----
// Purpose: shared constants and types of the touch key readout block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   register index times four is the byte address
package touch_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_IE_MAIN    = 8'ha8;
    localparam logic [7:0] IDX_IE_EXTRA   = 8'ha9;
    localparam logic [7:0] IDX_SHARED     = 8'haa;
    localparam logic [7:0] IDX_CONV_HIGH  = 8'hab;
    localparam logic [7:0] IDX_COUNT_LOW  = 8'hac;
    localparam logic [7:0] IDX_TRIM       = 8'had;
    localparam logic [7:0] IDX_CONTROL    = 8'hae;
    localparam logic [7:0] IDX_REF_LOW    = 8'hb4;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hb8;
    localparam logic [7:0] IDX_IRQ_MASK   = 8'hb9;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTRL_PD_BIT     = 7;
    localparam int CTRL_EOC_BIT    = 6;
    localparam int IE_GLOBAL_BIT   = 7;
    localparam int EXTRA_CONV_BIT  = 3;
    localparam int STAT_TOUCH_BIT  = 0;
    localparam int STAT_CONV_BIT   = 1;
    localparam int TRIM_W          = 7;
    localparam int CHS_W           = 4;
    localparam int COUNT_W         = 12;
    localparam int REF_W           = 8;
    localparam int STAT_W          = 2;

    // ----------------------------------------------------------------
    // reset values and codes
    // ----------------------------------------------------------------
    localparam logic              PD_RESET      = 1'b1;
    localparam logic [TRIM_W-1:0] TRIM_RESET    = 7'h40;
    localparam logic [CHS_W-1:0]  CHS_RESET     = 4'hf;
    localparam logic [CHS_W-1:0]  CHS_REFERENCE = 4'hf;
    localparam logic [REF_W-1:0]  REF_RESET     = 8'hff;
    localparam logic [1:0]        HTRANS_NONSEQ = 2'b10;
    localparam logic              HRESP_OKAY    = 1'b0;

    // ----------------------------------------------------------------
    // timing: one reference count step lasts REF_TICK_NS
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 10;
    localparam int REF_TICK_NS     = 80;
    localparam int REF_TICK_CYCLES =
        (REF_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // measurement engine states
    typedef enum logic [1:0] {
        MEAS_IDLE = 2'b01,
        MEAS_RUN  = 2'b10
    } meas_state_t;

endpackage : touch_pkg

// ---- core/touch_counter.sv ----
// Purpose: counts oscillator edges of one touch pad over a timed window
// Assumes: osc is a synchronous level, window = (ref+1) reference steps
// Notes:   count saturates, never wraps
`timescale 1ns/1ps
module touch_counter #(
    parameter int CNT_W = touch_pkg::COUNT_W,
    parameter int RW    = touch_pkg::REF_W
) (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // control
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic [RW-1:0]    ref_count,
    // oscillator of selected pad
    input  wire logic             osc,
    // result
    output logic      [CNT_W-1:0] count,
    output logic                  done,
    output logic                  busy
);
    import touch_pkg::*;

    localparam int TICK_W = $clog2(REF_TICK_CYCLES + 1);
    localparam logic [TICK_W-1:0] TICK_LAST =
        TICK_W'(REF_TICK_CYCLES - 1);

    meas_state_t       state, next_state;
    logic [RW-1:0]     ref_left, next_ref_left;
    logic [TICK_W-1:0] tick, next_tick;
    logic [CNT_W-1:0]  next_count;
    logic              osc_prev, next_done;

    // next-state of the measurement window
    always_comb begin
        next_state    = state;
        next_ref_left = ref_left;
        next_tick     = tick;
        next_count    = count;
        next_done     = 1'b0;
        case (state)
            MEAS_IDLE: begin
                if (start) begin
                    next_state    = MEAS_RUN;
                    next_ref_left = ref_count;
                    next_tick     = '0;
                    next_count    = '0;
                end
            end
            MEAS_RUN: begin
                // power-down ends a window early without done; the partial count is held
                if (abort) begin
                    next_state = MEAS_IDLE;
                end else begin
                    if (osc && !osc_prev && count != '1)
                        next_count = count + CNT_W'(1);
                    if (tick == TICK_LAST) begin
                        next_tick = '0;
                        if (ref_left == '0) begin
                            next_state = MEAS_IDLE;
                            next_done  = 1'b1;
                        end else begin
                            next_ref_left = ref_left - RW'(1);
                        end
                    end else begin
                        next_tick = tick + TICK_W'(1);
                    end
                end
            end
            default: next_state = MEAS_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state    <= MEAS_IDLE;
            ref_left <= '0;
            tick     <= '0;
            count    <= '0;
            done     <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            state    <= next_state;
            ref_left <= next_ref_left;
            tick     <= next_tick;
            count    <= next_count;
            done     <= next_done;
            osc_prev <= osc;
        end
    end

    assign busy = (state == MEAS_RUN);

    // (R8) count never wraps
    a_count_saturates: assert property (  // (R8)
        @(posedge hclk) disable iff (!hresetn)
        busy && count == '1 |=> count == '1)
        else $error("touch count wrapped");

    // (R2) done only ends a run
    a_done_ends_run: assert property (  // (R2)
        @(posedge hclk) disable iff (!hresetn)
        done |-> $past(busy) && !busy)
        else $error("done without a finished window");

endmodule : touch_counter

// ---- core/touch_key_adc_readout.sv ----
// Purpose: register readout of the touch key unit and ADC result
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes:   status bits clear on read; ADC converter sits outside
`timescale 1ns/1ps

// Summary of operation
// (R1) power-down bit, reset 1, stops measuring
// (R2) end flag 0 while measuring, reset 1
// (R3) codes 0-14 pick pads, 15 reference key
// (R4) touch count bits 11-8 in shared low nibble
// (R5) touch count bits 7-0 in own register
// (R6) ADC bits 11-4 in high register
// (R7) ADC bits 3-0 in shared high nibble
// (R8) trim, reset 40h, drives oscillator capacitor
// (R9) firmware tunes trim to reference ratio
// (R10) combined enable lets ADC/touch interrupt through
// (R11) global enable 0 blocks all requests
// (R12) writable reference low byte, reset FFh
// (R13) finished measurement raises enabled interrupt
module touch_key_adc_readout #(
    parameter int PADS = 15
) (
    // clock and reset
    input  wire logic                            hclk,
    input  wire logic                            hresetn,
    // ahb-lite slave
    input  wire logic                            hsel,
    input  wire logic [31:0]                     haddr,
    input  wire logic [1:0]                      htrans,
    input  wire logic                            hwrite,
    input  wire logic [2:0]                      hsize,
    input  wire logic [31:0]                     hwdata,
    input  wire logic                            hready,
    output logic      [31:0]                     hrdata,
    output logic                                 hreadyout,
    output logic                                 hresp,
    // touch pads and reference key oscillators
    input  wire logic [PADS-1:0]                 touch_inputs,
    input  wire logic                            ref_key_osc,
    // adc converter result
    input  wire logic [touch_pkg::COUNT_W-1:0]   adc_result,
    input  wire logic                            adc_done,
    // analog controls
    output logic                                 touch_power_down,
    output logic      [touch_pkg::CHS_W-1:0]     touch_channel_select,
    output logic      [touch_pkg::TRIM_W-1:0]    touch_capacitor_trim,
    // interrupt
    output logic                                 irq
);
    import touch_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [7:0]         interrupt_enable_main, next_ie_main;
    logic [7:0]         interrupt_enable_extra, next_ie_extra;
    logic [REF_W-1:0]   touch_reference_count, next_ref;
    logic [STAT_W-1:0]  irq_mask, next_mask;
    logic [STAT_W-1:0]  irq_status, next_status;
    logic [COUNT_W-1:0] adc_data, next_adc_data;
    logic [TRIM_W-1:0]  next_trim;
    logic [CHS_W-1:0]   next_chs;
    logic               next_pd;
    logic               wr_pend, next_wr_pend;
    logic [7:0]         wr_idx, next_wr_idx;
    logic [31:0]        next_hrdata;
    logic [7:0]         rd_byte;
    logic               req, addr_ok, meas_start;
    logic               selected_osc, meas_done, meas_busy;
    logic               touch_conversion_done;
    logic               global_irq_enable, conv_touch_irq_enable;
    logic [STAT_W-1:0]  events, read_clear;
    logic [COUNT_W-1:0] touch_count_value;
    logic [7:0]         idx;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    // zero wait states, every answer okay
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;
    assign req       = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign idx       = haddr[9:2];
    // word aligned, inside the block's window; others read zero
    assign addr_ok   = (haddr[31:10] == '0) && (haddr[1:0] == 2'b00);

    // (R2) flag low while a window runs
    assign touch_conversion_done = !meas_busy;
    // (R11) enables split out of their registers
    assign global_irq_enable     = interrupt_enable_main[IE_GLOBAL_BIT];
    assign conv_touch_irq_enable = interrupt_enable_extra[EXTRA_CONV_BIT];

    // ----------------------------------------------------------------
    // pad selection and measurement
    // ----------------------------------------------------------------
    // (R3) code 15 picks the reference key
    always_comb begin
        if (touch_channel_select == CHS_REFERENCE)
            selected_osc = ref_key_osc;
        else
            selected_osc = touch_inputs[touch_channel_select];
    end

    // (R1) start only on a write that clears power-down
    assign meas_start = wr_pend && (wr_idx == IDX_CONTROL)
                        && !hwdata[CTRL_PD_BIT];

    touch_counter #(
        .CNT_W     (COUNT_W),
        .RW        (REF_W)
    ) touch_counter_i (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .start     (meas_start),
        .abort     (touch_power_down),
        .ref_count (touch_reference_count),
        .osc       (selected_osc),
        .count     (touch_count_value),
        .done      (meas_done),
        .busy      (meas_busy)
    );

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    // data sampled in address phase, shown in data phase
    always_comb begin
        rd_byte = 8'h00;
        if (!addr_ok) begin
            rd_byte = 8'h00;
        end else if (idx == IDX_IE_MAIN) begin
            rd_byte = interrupt_enable_main;
        end else if (idx == IDX_IE_EXTRA) begin
            rd_byte = interrupt_enable_extra;
        end else if (idx == IDX_SHARED) begin
            // (R4) (R7) adc low nibble over touch high nibble
            rd_byte = {adc_data[3:0], touch_count_value[11:8]};
        end else if (idx == IDX_CONV_HIGH) begin
            // (R6) adc upper byte
            rd_byte = adc_data[11:4];
        end else if (idx == IDX_COUNT_LOW) begin
            // (R5) touch lower byte
            rd_byte = touch_count_value[7:0];
        end else if (idx == IDX_TRIM) begin
            rd_byte = {1'b0, touch_capacitor_trim};
        end else if (idx == IDX_CONTROL) begin
            rd_byte = {touch_power_down, touch_conversion_done,
                       2'b00, touch_channel_select};
        end else if (idx == IDX_REF_LOW) begin
            rd_byte = touch_reference_count;
        end else if (idx == IDX_IRQ_STATUS) begin
            rd_byte = {6'h00, irq_status};
        end else if (idx == IDX_IRQ_MASK) begin
            rd_byte = {6'h00, irq_mask};
        end
        next_hrdata = {24'h000000, rd_byte};
    end

    // ----------------------------------------------------------------
    // writable registers
    // ----------------------------------------------------------------
    // write data arrives one cycle after its address phase
    always_comb begin
        next_wr_pend  = req && hwrite && addr_ok;
        next_wr_idx   = idx;
        next_ie_main  = interrupt_enable_main;
        next_ie_extra = interrupt_enable_extra;
        next_trim     = touch_capacitor_trim;
        next_pd       = touch_power_down;
        next_chs      = touch_channel_select;
        next_ref      = touch_reference_count;
        next_mask     = irq_mask;
        if (wr_pend) begin
            if (wr_idx == IDX_IE_MAIN) begin
                next_ie_main = hwdata[7:0];
            end else if (wr_idx == IDX_IE_EXTRA) begin
                next_ie_extra = hwdata[7:0];
            end else if (wr_idx == IDX_TRIM) begin
                // (R8) trim goes straight to the capacitor bank
                next_trim = hwdata[TRIM_W-1:0];
            end else if (wr_idx == IDX_CONTROL) begin
                // (R1) power-down bit, end flag is read only
                next_pd  = hwdata[CTRL_PD_BIT];
                next_chs = hwdata[CHS_W-1:0];
            end else if (wr_idx == IDX_REF_LOW) begin
                // (R12) window length for the next start
                next_ref = hwdata[REF_W-1:0];
            end else if (wr_idx == IDX_IRQ_MASK) begin
                next_mask = hwdata[STAT_W-1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend                <= 1'b0;
            wr_idx                 <= 8'h00;
            interrupt_enable_main  <= 8'h00;
            interrupt_enable_extra <= 8'h00;
            touch_capacitor_trim   <= TRIM_RESET;
            touch_power_down       <= PD_RESET;
            touch_channel_select   <= CHS_RESET;
            touch_reference_count  <= REF_RESET;
            irq_mask               <= '0;
        end else begin
            wr_pend                <= next_wr_pend;
            wr_idx                 <= next_wr_idx;
            interrupt_enable_main  <= next_ie_main;
            interrupt_enable_extra <= next_ie_extra;
            touch_capacitor_trim   <= next_trim;
            touch_power_down       <= next_pd;
            touch_channel_select   <= next_chs;
            touch_reference_count  <= next_ref;
            irq_mask               <= next_mask;
        end
    end

    // ----------------------------------------------------------------
    // status, adc capture, read data
    // ----------------------------------------------------------------
    // set wins over read clear so no event is lost
    always_comb begin
        events        = '0;
        events[STAT_TOUCH_BIT] = meas_done;
        events[STAT_CONV_BIT]  = adc_done;
        read_clear    = (req && !hwrite && addr_ok
                         && idx == IDX_IRQ_STATUS) ? '1 : '0;
        next_status   = (irq_status & ~read_clear) | events;
        next_adc_data = adc_done ? adc_result : adc_data;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= '0;
            adc_data   <= '0;
            hrdata     <= 32'h00000000;
        end else begin
            irq_status <= next_status;
            adc_data   <= next_adc_data;
            hrdata     <= next_hrdata;
        end
    end

    // (R10) (R11) (R13) gated request line
    assign irq = global_irq_enable && conv_touch_irq_enable
                 && |(irq_status & irq_mask);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_rd(logic [7:0] ri);
        req && !hwrite && addr_ok && idx == ri;
    endsequence

    sequence s_wr(logic [7:0] ri);
        req && hwrite && addr_ok && idx == ri;
    endsequence

    a_pd_stays_idle: assert property (  // (R1)
        @(posedge hclk) disable iff (!hresetn)
        touch_power_down && $past(touch_power_down)
        |-> touch_conversion_done)
        else $error("measurement ran while powered down");

    a_start_clears_eoc: assert property (  // (R2)
        @(posedge hclk) disable iff (!hresetn)
        s_wr(IDX_CONTROL) ##1 (!hwdata[CTRL_PD_BIT] && !meas_busy)
        |=> !touch_conversion_done)
        else $error("end flag not cleared by start");

    a_chs_reference: assert property (  // (R3)
        @(posedge hclk) disable iff (!hresetn)
        touch_channel_select == CHS_REFERENCE
        |-> selected_osc == ref_key_osc)
        else $error("code 15 did not pick reference key");

    a_shared_read: assert property (  // (R4)
        @(posedge hclk) disable iff (!hresetn)
        s_rd(IDX_SHARED) |=> hrdata == {24'h000000,
            $past(adc_data[3:0]), $past(touch_count_value[11:8])})
        else $error("shared register read wrong");

    a_low_read: assert property (  // (R5)
        @(posedge hclk) disable iff (!hresetn)
        s_rd(IDX_COUNT_LOW) |=>
        hrdata[7:0] == $past(touch_count_value[7:0]))
        else $error("touch low byte read wrong");

    a_high_read: assert property (  // (R6)
        @(posedge hclk) disable iff (!hresetn)
        s_rd(IDX_CONV_HIGH) |=>
        hrdata[7:0] == $past(adc_data[11:4]))
        else $error("adc high byte read wrong");

    a_trim_write: assert property (  // (R8)
        @(posedge hclk) disable iff (!hresetn)
        s_wr(IDX_TRIM) ##1 1'b1 |=>
        touch_capacitor_trim == $past(hwdata[TRIM_W-1:0]))
        else $error("trim write lost");

    a_global_blocks: assert property (  // (R11)
        @(posedge hclk) disable iff (!hresetn)
        !global_irq_enable || !conv_touch_irq_enable |-> !irq)
        else $error("irq with enables off");

    a_ref_write: assert property (  // (R12)
        @(posedge hclk) disable iff (!hresetn)
        s_wr(IDX_REF_LOW) ##1 1'b1 |=>
        touch_reference_count == $past(hwdata[REF_W-1:0]))
        else $error("reference write lost");

    a_done_raises_irq: assert property (  // (R13)
        @(posedge hclk) disable iff (!hresetn)
        meas_done && irq_mask[STAT_TOUCH_BIT]
        && global_irq_enable && conv_touch_irq_enable
        && $stable(interrupt_enable_main)
        ##1 $stable(interrupt_enable_main) && $stable(irq_mask)
        && $stable(interrupt_enable_extra) |-> irq)
        else $error("finished measurement did not raise irq");

endmodule : touch_key_adc_readout

// ---- tb/touch_pad_model.sv ----
// Purpose: free-running pad oscillators seen by the touch counter
// Assumes: pad i toggles every i+2 cycles, reference key every cycle
// Notes:   levels are synchronous to hclk, so edge counts are exact
`timescale 1ns/1ps
module touch_pad_model (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // oscillator levels
    output logic      [14:0] touch_inputs,
    output logic             ref_key_osc
);
    int cyc;

    // ----------------------------------------------------------------
    // oscillators
    // ----------------------------------------------------------------
    // cycle count used as the common time base
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cyc <= 0;
        end else begin
            cyc <= cyc + 1;
        end
    end

    // slower pads give fewer edges, so channel mixups show up
    always_comb begin
        for (int i = 0; i < 15; i++) begin
            touch_inputs[i] = ((cyc / (i + 2)) % 2) == 1;
        end
        ref_key_osc = cyc[0];
    end
endmodule : touch_pad_model

// ---- tb/touch_key_adc_readout_tb_top.sv ----
// Purpose: register-level tests of the touch key readout
// Assumes: zero-wait ahb-lite slave, window (ref+1)*8 cycles
// Notes:   counts checked to within one edge of the pad rate
`timescale 1ns/1ps
module touch_key_adc_readout_tb_top;
    import touch_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic        ref_key_osc, adc_done, touch_power_down, irq;
    logic [31:0] haddr, hwdata, hrdata, v, lo, sh;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [14:0] touch_inputs;
    logic [11:0] adc_result, cnt;
    logic [3:0]  touch_channel_select;
    logic [6:0]  touch_capacitor_trim;
    logic [3:0]  chans [3] = '{4'h0, 4'he, 4'hf};
    int          exps [3] = '{32, 4, 64};
    int          mismatches, compares, n;

    assign hready = hreadyout;

    touch_key_adc_readout touch_key_adc_readout_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .touch_inputs(touch_inputs),
        .ref_key_osc(ref_key_osc), .adc_result(adc_result),
        .adc_done(adc_done), .touch_power_down(touch_power_down),
        .touch_channel_select(touch_channel_select),
        .touch_capacitor_trim(touch_capacitor_trim), .irq(irq));
    touch_pad_model touch_pad_model_i (.hclk(hclk), .hresetn(hresetn),
        .touch_inputs(touch_inputs), .ref_key_osc(ref_key_osc));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // ----------------------------------------------------------------
    // bus and check tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // one single transfer; hold each phase until hready is seen high
    task automatic xfer(input logic w, input logic [7:0] idx, wd,
                        output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        chk("hresp", hresp, HRESP_OKAY);
    endtask : xfer

    task automatic wr(input logic [7:0] idx, d);
        xfer(1'b1, idx, d, v);
    endtask : wr

    task automatic rchk(input string nm, input logic [7:0] idx,
                        input logic [31:0] e);
        xfer(1'b0, idx, 8'h00, v);
        chk(nm, v, e);
    endtask : rchk

    task automatic results();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    // watchdog: tests need a few hundred cycles
    initial begin
        #300000;
        mismatches++;
        results();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        hresetn = 1'b0;
        {hsel, haddr, htrans, hwrite, hwdata, adc_result, adc_done} = '0;
        hsize = 3'b010;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("pd port", touch_power_down, 1);
        rchk("control", IDX_CONTROL, 32'hcf);
        rchk("trim", IDX_TRIM, 32'h40);
        rchk("ie main", IDX_IE_MAIN, 0);
        rchk("ie extra", IDX_IE_EXTRA, 0);
        rchk("ref low", IDX_REF_LOW, 32'hff);
        rchk("unmapped", 8'h10, 0);
        $display("test reset_values done");
        // channel change while powered down must not start a window
        wr(IDX_CONTROL, 8'h83);
        rchk("control pd", IDX_CONTROL, 32'hc3);
        chk("chs port", touch_channel_select, 4'h3);
        // firmware picks the trim; pads here ignore it
        wr(IDX_TRIM, 8'hff);
        rchk("trim max", IDX_TRIM, 32'h7f);
        chk("trim port", touch_capacitor_trim, 7'h7f);
        wr(IDX_REF_LOW, 8'h0f);
        rchk("ref set", IDX_REF_LOW, 32'h0f);
        wr(IDX_IRQ_MASK, 8'h03);
        $display("test registers done");
        // pass 0 global off, pass 1 combined enable off, pass 2 both on
        for (int i = 0; i < 3; i++) begin
            wr(IDX_IE_MAIN, (i == 0) ? 8'h00 : 8'h80);
            wr(IDX_IE_EXTRA, (i == 1) ? 8'h00 : 8'h08);
            wr(IDX_CONTROL, {4'h0, chans[i]});
            // port is looked at after the write edge has settled
            rchk("busy", IDX_CONTROL, {28'h0, chans[i]});
            chk("pd off", touch_power_down, 0);
            n = 0;
            do begin
                xfer(1'b0, IDX_CONTROL, 8'h00, v);
                n++;
            end while (v[6] !== 1'b1 && n < 300);
            chk("end flag", v, {24'h0, 4'h4, chans[i]});
            repeat (2) @(posedge hclk);
            #1 chk("irq gate", irq, (i == 2));
            if (i == 1) begin
                wr(IDX_IE_EXTRA, 8'h08);
                #1 chk("irq enable", irq, 1);
            end
            xfer(1'b0, IDX_COUNT_LOW, 8'h00, lo);
            xfer(1'b0, IDX_SHARED, 8'h00, sh);
            cnt = {sh[3:0], lo[7:0]};
            chk("count", cnt >= exps[i] - 1 && cnt <= exps[i] + 1, 1);
            chk("count high", sh[3:0], cnt[11:8]);
            rchk("status", IDX_IRQ_STATUS, 1);
            #1 chk("irq clear", irq, 0);
            $display("test measure %0d done", i);
        end
        // converter result lands in the shared and high registers
        @(posedge hclk);
        adc_result <= 12'habc;
        adc_done   <= 1'b1;
        @(posedge hclk);
        adc_done   <= 1'b0;
        repeat (2) @(posedge hclk);
        #1 chk("irq adc", irq, 1);
        rchk("adc high", IDX_CONV_HIGH, 32'hab);
        rchk("shared", IDX_SHARED, {24'h0, 4'hc, sh[3:0]});
        rchk("status adc", IDX_IRQ_STATUS, 2);
        $display("test adc done");
        results();
    end
endmodule : touch_key_adc_readout_tb_top
